// ==== verilog/rtcal_defines.vh ====
/*
  Register offsets, field positions and widths of the alarm register block.
  Assumes nothing; definitions only.
*/
`ifndef RTCAL_DEFINES_VH
`define RTCAL_DEFINES_VH

`define RTCAL_OFS_WMIN 4'h8
`define RTCAL_OFS_WHOUR 4'h9
`define RTCAL_OFS_WDAY 4'ha
`define RTCAL_OFS_DMIN 4'hb
`define RTCAL_OFS_DHOUR 4'hc
`define RTCAL_MIN_W 7
`define RTCAL_HOUR_W 6
`define RTCAL_DAY_W 7
`define RTCAL_PM_BIT 5
`define RTCAL_DOW_LAST 3'h6
`define RTCAL_HOUR_MID12 6'h12
`define RTCAL_HOUR_NOON12 6'h32

`endif

// ==== verilog/rtcal_match.v ====
/*
  Minute and hour comparator for one alarm.
  Assumes alarm and counter values share the same hour encoding.
*/
`timescale 1ns/1ps
module rtcal_match (
  input wire [6:0] cur_min,    // Current minute, BCD
  input wire [5:0] cur_hour,   // Current hour, BCD
  input wire [6:0] alm_min,    // Alarm minute, BCD
  input wire [5:0] alm_hour,   // Alarm hour, BCD
  input wire day_ok,           // Day qualifier
  output wire hit              // Time and day match
);
  assign hit = day_ok && (cur_min == alm_min) && (cur_hour == alm_hour);
endmodule

// ==== verilog/rtcal_dow.v ====
/*
  Day-of-week counter, modulo seven.
  Assumes day_carry is a one-cycle pulse on mclk.
*/
`timescale 1ns/1ps
`include "rtcal_defines.vh"
module rtcal_dow (
  input wire mclk,             // Clock
  input wire reset,            // Async reset, active high
  input wire day_carry,        // Day rollover pulse
  input wire dow_load,         // Load strobe
  input wire [2:0] dow_load_val, // Load value
  output wire [2:0] day_of_week_code // Current day code
);
  reg [2:0] dow_q;
  reg [2:0] dow_d;

  always @*
  begin
    dow_d = dow_q;
    if (dow_load)
      dow_d = dow_load_val;
    else if (day_carry)
    begin
      // R13 modulo seven wrap
      if (dow_q >= `RTCAL_DOW_LAST)
        dow_d = 3'h0;
      else
        dow_d = dow_q + 3'h1;
    end
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      dow_q <= 3'h0;
    else
      dow_q <= dow_d;
  end

  assign day_of_week_code = dow_q;
endmodule

// ==== verilog/rtcal_regs.v ====
/*
  Alarm register block: weekly and daily alarm registers, read port,
  and alarm match events.
  Assumes the serial bus engine supplies reg_addr, reg_wr and reg_wdata
  on mclk, and the time counters supply current minute, hour and mode.
*/
`timescale 1ns/1ps
`include "rtcal_defines.vh"
// Summary of operation
// R1 - Weekly minute at 8h, bit7 zero
// R2 - Weekly hour at 9h, bits7:6 zero
// R3 - Weekly day mask at Ah, bit7 zero
// R4 - Daily minute at Bh, bit7 zero
// R5 - Daily hour at Ch, bits7:6 zero
// R6 - Weekly hour bit5 is PM or tens
// R7 - Daily hour bit5 is PM or tens
// R8 - Midnight 12, noon 32 in 12-hour
// R9 - Mask bit n selects day code n
// R10 - Empty mask suppresses weekly alarm
// R11 - Host writes only real times
// R12 - Power-up fields undefined, high bits zero
// R13 - Day counter counts modulo seven
// R14 - Match minute, hour, day raises event
// R15 - Compare in counters' hour encoding
module rtcal_regs (
  input wire mclk,              // Clock, 250 MHz
  input wire reset,             // Async reset, active high
  input wire [3:0] reg_addr,    // Internal register address
  input wire reg_wr,            // Write strobe, one cycle
  input wire [7:0] reg_wdata,   // Write data
  input wire [6:0] cur_min,     // Current minute, BCD
  input wire [5:0] cur_hour,    // Current hour, BCD, same mode encoding
  input wire mode_24h,          // Hour mode, 1 = 24-hour
  input wire min_tick,          // Minute rollover pulse
  input wire day_carry,         // Day rollover pulse
  input wire dow_load,          // Day counter load strobe
  input wire [2:0] dow_load_val, // Day counter load value
  output reg [7:0] reg_rdata,   // Read data of addressed register
  output reg weekly_alarm_event, // Weekly alarm match pulse
  output reg daily_alarm_event, // Daily alarm match pulse
  output reg [2:0] day_of_week_q, // Day code, registered
  output reg weekly_pm_q,       // Weekly hour bit5 read as PM flag
  output reg daily_alarm_pm_flag // Daily hour bit5 read as PM flag
);
  reg [6:0] weekly_alarm_minute_bcd;
  reg [5:0] weekly_alarm_hour_bcd;
  reg [6:0] weekly_alarm_day_enables;
  reg [6:0] daily_alarm_minute_bcd;
  reg [5:0] daily_alarm_hour_bcd;
  reg [7:0] rdata_d;
  reg tick_q;
  wire [2:0] day_of_week_code;
  wire week_day_ok;
  wire week_hit;
  wire day_hit;

  // R12 alarm fields have no reset value
  always @(posedge mclk)
  begin
    if (reg_wr)
    begin
      case (reg_addr)
        // R1 weekly minute store
        `RTCAL_OFS_WMIN: weekly_alarm_minute_bcd <= reg_wdata[6:0];
        // R2 weekly hour store
        `RTCAL_OFS_WHOUR: weekly_alarm_hour_bcd <= reg_wdata[5:0];
        // R3 day mask store
        `RTCAL_OFS_WDAY: weekly_alarm_day_enables <= reg_wdata[6:0];
        // R4 daily minute store
        `RTCAL_OFS_DMIN: daily_alarm_minute_bcd <= reg_wdata[6:0];
        // R5 daily hour store
        `RTCAL_OFS_DHOUR: daily_alarm_hour_bcd <= reg_wdata[5:0];
        default:
        begin
        end
      endcase
    end
  end

  // R12 unused high bits read zero
  always @*
  begin
    case (reg_addr)
      `RTCAL_OFS_WMIN: rdata_d = {1'b0, weekly_alarm_minute_bcd};
      `RTCAL_OFS_WHOUR: rdata_d = {2'b00, weekly_alarm_hour_bcd};
      `RTCAL_OFS_WDAY: rdata_d = {1'b0, weekly_alarm_day_enables};
      `RTCAL_OFS_DMIN: rdata_d = {1'b0, daily_alarm_minute_bcd};
      `RTCAL_OFS_DHOUR: rdata_d = {2'b00, daily_alarm_hour_bcd};
      default: rdata_d = 8'h00;
    endcase
  end

  rtcal_dow u_dow (
    .mclk(mclk),
    .reset(reset),
    .day_carry(day_carry),
    .dow_load(dow_load),
    .dow_load_val(dow_load_val),
    .day_of_week_code(day_of_week_code)
  );

  // R9 R10 day select; empty mask never matches
  assign week_day_ok = (day_of_week_code <= `RTCAL_DOW_LAST) &&
    weekly_alarm_day_enables[day_of_week_code];

  // R14 R15 R8 weekly compare, raw BCD codes
  rtcal_match u_week (
    .cur_min(cur_min),
    .cur_hour(cur_hour),
    .alm_min(weekly_alarm_minute_bcd),
    .alm_hour(weekly_alarm_hour_bcd),
    .day_ok(week_day_ok),
    .hit(week_hit)
  );

  // R14 R15 daily compare
  rtcal_match u_day (
    .cur_min(cur_min),
    .cur_hour(cur_hour),
    .alm_min(daily_alarm_minute_bcd),
    .alm_hour(daily_alarm_hour_bcd),
    .day_ok(1'b1),
    .hit(day_hit)
  );

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
      weekly_alarm_event <= 1'b0;
      daily_alarm_event <= 1'b0;
      day_of_week_q <= 3'h0;
      weekly_pm_q <= 1'b0;
      daily_alarm_pm_flag <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      reg_rdata <= rdata_d;
      day_of_week_q <= day_of_week_code;
      // Counters settle one cycle after the tick
      tick_q <= min_tick;
      weekly_alarm_event <= tick_q && week_hit;
      daily_alarm_event <= tick_q && day_hit;
      // R6 bit5 is PM only in 12-hour mode
      weekly_pm_q <= !mode_24h &&
        weekly_alarm_hour_bcd[`RTCAL_PM_BIT];
      // R7 bit5 is PM only in 12-hour mode
      daily_alarm_pm_flag <= !mode_24h &&
        daily_alarm_hour_bcd[`RTCAL_PM_BIT];
    end
  end
endmodule

// ==== bench/rtcal_host.sv ====
/* Time counter model feeding the alarm block.
   Assumes tick is called at a falling edge. */
`timescale 1ns/1ps
module rtcal_host (
  input wire mclk, // Clock
  output reg [6:0] cur_min = 7'h00, // Minute
  output reg [5:0] cur_hour = 6'h00, // Hour
  output reg min_tick = 1'b0 // Tick
);
  task tick(input [6:0] m, input [5:0] h);
  begin
    cur_min = m;
    cur_hour = h;
    min_tick = 1'b1;
    @(negedge mclk);
    min_tick = 1'b0;
  end
  endtask
endmodule

// ==== bench/rtcal_regs_asserts.sv ====
/* Port checker of the alarm registers.
   Assumes it is bound to rtcal_regs. */
`timescale 1ns/1ps
module rtcal_chk (
  input wire mclk, // Clock
  input wire reset, // Reset
  input wire [3:0] reg_addr, // Addr
  input wire reg_wr, // Write
  input wire [7:0] reg_wdata, // Data
  input wire mode_24h, // Mode
  input wire min_tick, // Tick
  input wire [7:0] reg_rdata, // Read
  input wire daily_alarm_event, // Event
  input wire [2:0] day_of_week_q, // Day
  input wire daily_alarm_pm_flag // PM
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_rd_top: assert property (
    $past(reg_addr) inside {4'h8, 4'ha, 4'hb} |-> !reg_rdata[7])
    else $error("bit 7 set");
  chk_rd_hi: assert property (
    $past(reg_addr) inside {4'h9, 4'hc} |-> reg_rdata[7:6] == 2'b00)
    else $error("hour top bits");
  chk_rd_unmap: assert property (
    !($past(reg_addr) inside {[4'h8:4'hc]}) |-> reg_rdata == 8'h00)
    else $error("unmapped read");
  chk_wr_rd: assert property (
    reg_wr && reg_addr == 4'h9 ##1 reg_addr == 4'h9
    |=> reg_rdata == {2'b00, $past(reg_wdata[5:0], 2)})
    else $error("hour readback");
  chk_ev_pulse: assert property (
    daily_alarm_event |=> !daily_alarm_event)
    else $error("event too long");
  chk_ev_cause: assert property (
    daily_alarm_event |-> $past(min_tick, 2))
    else $error("event without tick");
  chk_pm_mode: assert property (
    $past(mode_24h) |-> !daily_alarm_pm_flag)
    else $error("pm in 24h");
  chk_dow_range: assert property (
    day_of_week_q != 3'h7)
    else $error("day code 7");
  cover property (daily_alarm_event);
  cover property (daily_alarm_pm_flag);
  cover property (day_of_week_q == 3'h6);
endmodule
bind rtcal_regs rtcal_chk chk (.*);

// ==== bench/rtcal_regs_tb.sv ====
/* Self-checking bench of the alarm registers.
   Assumes the time model and a 4 ns clock. */
`timescale 1ns/1ps
module rtcal_regs_tb;
  reg mclk = 1'b0;
  reg reset = 1'b1;
  reg [3:0] a = 4'h0;
  reg wr_en = 1'b0;
  reg [7:0] d = 8'h00;
  reg m24 = 1'b0;
  reg dc = 1'b0;
  reg ld = 1'b0;
  reg [2:0] lv = 3'h0;
  reg [1:0] want = 2'h0;
  reg [1:0] pend = 2'h0;
  reg [7:0] eq[$];
  reg [31:0] x = 32'he7bcee19;
  wire [6:0] cm;
  wire [5:0] ch;
  wire tk, we, de, wp, dp;
  wire [7:0] rd;
  wire [2:0] dw;
  integer n_fail = 0;
  integer n_compared = 0;
  integer i;
  rtcal_host host (.mclk(mclk), .cur_min(cm), .cur_hour(ch), .min_tick(tk));
  rtcal_regs uut (.mclk(mclk), .reset(reset), .reg_addr(a), .reg_wr(wr_en),
    .reg_wdata(d), .cur_min(cm), .cur_hour(ch), .mode_24h(m24),
    .min_tick(tk), .day_carry(dc), .dow_load(ld), .dow_load_val(lv),
    .reg_rdata(rd), .weekly_alarm_event(we), .daily_alarm_event(de),
    .day_of_week_q(dw), .weekly_pm_q(wp), .daily_alarm_pm_flag(dp));
  initial
    forever #2 mclk = ~mclk;
  function [31:0] rnd(input [31:0] v);
  begin
    rnd = v ^ (v << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
  end
  endfunction
  task end_sim;
  begin
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task check(input [7:0] g, input [7:0] e);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  end
  endtask
  task wr(input [3:0] ad, input [7:0] v);
  begin
    a = ad;
    d = v;
    wr_en = 1'b1;
    @(negedge mclk);
    wr_en = 1'b0;
    @(negedge mclk);
  end
  endtask
  // Note an expectation, compared two edges on
  task note(input [1:0] m, input [7:0] e);
  begin
    eq.push_back(e);
    want = m;
    @(negedge mclk);
    want = 2'h0;
    @(negedge mclk);
  end
  endtask
  task ev(input [6:0] mi, input [5:0] hr, input [7:0] e);
  begin
    host.tick(mi, hr);
    note(2'h2, e);
  end
  endtask
  task day(input l, input [2:0] v);
  begin
    ld = l;
    lv = v;
    dc = !l;
    @(negedge mclk);
    ld = 1'b0;
    dc = 1'b0;
  end
  endtask
  always @(posedge mclk)
    pend <= want;
  always @(negedge mclk)
  begin
    if (pend == 2'h1)
      check(rd, eq.pop_front());
    if (pend == 2'h2)
      check({6'h0, we, de}, eq.pop_front());
    if (pend == 2'h3)
      check({3'h0, dw, wp, dp}, eq.pop_front());
  end
  initial
  begin
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    for (i = 8; i < 13; i = i + 1)
    begin
      x = rnd(x);
      wr(i[3:0], x[7:0]);
      note(2'h1, x[7:0] & (i % 3 == 0 ? 8'h3f : 8'h7f));
    end
    wr(4'hd, 8'hff);
    note(2'h1, 8'h00);
    wr(4'h8, 8'h30);
    wr(4'h9, 8'h32);
    wr(4'ha, 8'h00);
    wr(4'hb, 8'h30);
    wr(4'hc, 8'h32);
    ev(7'h30, 6'h32, 8'h01);
    note(2'h3, 8'h03);
    day(1'b1, 3'h5);
    wr(4'ha, 8'h20);
    ev(7'h30, 6'h32, 8'h03);
    ev(7'h31, 6'h32, 8'h00);
    day(1'b0, 3'h0);
    ev(7'h30, 6'h32, 8'h01);
    note(2'h3, 8'h1b);
    day(1'b0, 3'h0);
    note(2'h3, 8'h03);
    wr(4'hc, 8'h12);
    ev(7'h30, 6'h12, 8'h01);
    m24 = 1'b1;
    ev(7'h30, 6'h12, 8'h01);
    note(2'h3, 8'h00);
    end_sim;
  end
  initial
  begin
    #4000;
    n_fail = n_fail + 1;
    end_sim;
  end
endmodule
